/* File: hw/sac_pkg.sv */
// package for the converter control block: offsets, fields, states
// assumes a byte-wide register port and a comparator on the analog side
`default_nettype none
package sac_pkg;
	localparam int ADDR_W = 2;
	localparam logic [1:0] OFF_CSR = 2'h0;
	localparam logic [1:0] OFF_RES_HIGH = 2'h1;
	localparam logic [1:0] OFF_RES_LOW = 2'h2;
	localparam logic [1:0] OFF_IRQ_STATUS = 2'h3;
	localparam int BIT_DONE = 7;
	localparam int BIT_SPEED = 6;
	localparam int BIT_ON = 5;
	localparam int BIT_RSVD = 4;
	localparam logic [7:0] CSR_RESET = 8'h00;
	localparam logic [7:0] CSR_WRITE_MASK = 8'h6F;
	localparam logic [7:0] RES_RESET = 8'h00;
	localparam logic [7:0] LOW_MASK = 8'h03;
	localparam int RES_W = 10;
	localparam int CH_W = 4;
	localparam logic [1:0] DIV_SLOW = 2'h3;
	localparam logic [1:0] DIV_FAST = 2'h1;
	localparam int SAMPLE_TICKS = 2;
	localparam int IRQ_W = 2;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ABORT = 1;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_RESOLVE = 3'b100
	} sac_state_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} sac_bus_s;

	typedef struct packed {
		logic [CH_W-1:0] channel_select;
		logic sample;
		logic [RES_W-1:0] trial;
	} sac_analog_s;
endpackage
`default_nettype wire

/* File: hw/sac_adc_control.sv */
// control and result logic of a 10-bit successive-approximation converter
// assumes the comparator answer is synchronous to CLK_SYS
//
// Overview of operation
// - above high reference gives all ones
// - below low reference gives zero
// - converter_on starts continuous conversions
// - done flag and result at each end
// - high read or control write clears done
// - each conversion overwrites both result registers
// - channel change aborts and restarts conversion
// - speed bit picks divide by four or two
// - clearing converter_on stops conversion
// - channel_select picks input by binary value
// - high holds bits 9:2, low 1:0
// - done flag read-only, reserved bit 4 reads zero, other control bits read-write
// - all converter registers reset to zero
// - wait no effect, halt disables converter
//
// Local design decisions: the register offsets and the strobed register port.
`default_nettype none
module sac_adc_control
	import sac_pkg::*;
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// register port
	input wire sac_pkg::sac_bus_s BUS,
	output logic [7:0] RDATA,
	// power modes
	input wire logic HALT_MODE,
	// analog side
	input wire logic COMP_ABOVE,
	output sac_pkg::sac_analog_s ANALOG,
	// interrupt
	output logic IRQ
);
	import sac_pkg::*;

	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_n;
	logic [7:0] csr_reg;
	logic [7:0] res_high_reg;
	logic [7:0] res_low_reg;
	logic [7:0] rdata_reg;
	logic [1:0] div_reg;
	logic tick;
	sac_state_e state_reg;
	logic [RES_W-1:0] trial_reg;
	logic [3:0] bit_reg;
	logic [1:0] samp_reg;
	logic [IRQ_W-1:0] irq_status_reg;
	logic [IRQ_W-1:0] irq_mask_reg;
	logic irq_reg;
	logic csr_wr;
	logic high_rd;
	logic ch_change;
	logic conv_on;
	logic finish;
	logic [RES_W-1:0] final_res;

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	// reset release through two flops
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	assign csr_wr = BUS.wr && hit(BUS.addr, OFF_CSR);
	assign high_rd = BUS.rd && hit(BUS.addr, OFF_RES_HIGH);
	assign ch_change = csr_wr &&
		(BUS.wdata[CH_W-1:0] != csr_reg[CH_W-1:0]);
	assign conv_on = csr_reg[BIT_ON] && !HALT_MODE;
	assign final_res = {trial_reg[RES_W-1:1], COMP_ABOVE};
	assign finish = (state_reg == ST_RESOLVE) && tick &&
		(bit_reg == 4'h0) && !ch_change;

	// control register; done flag set wins over clear
	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
			csr_reg <= CSR_RESET;
		else
		begin
			if (csr_wr)
				csr_reg <= (BUS.wdata & CSR_WRITE_MASK) |
					(csr_reg & ~CSR_WRITE_MASK & ~(8'h80));
			else if (high_rd)
				csr_reg[BIT_DONE] <= 1'b0;
			if (finish)
				csr_reg[BIT_DONE] <= 1'b1;
		end
	end

	// converter clock divider
	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
			div_reg <= 2'h0;
		else if (!conv_on || tick || state_reg == ST_IDLE)
			div_reg <= 2'h0;
		else
			div_reg <= div_reg + 2'h1;
	end
	assign tick = conv_on && (state_reg != ST_IDLE) &&
		(div_reg == (csr_reg[BIT_SPEED] ? DIV_FAST : DIV_SLOW));

	// conversion sequencer
	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_IDLE;
			trial_reg <= 10'h000;
			bit_reg <= 4'h0;
			samp_reg <= 2'h0;
		end
		else if (!conv_on || ch_change)
		begin
			state_reg <= ST_IDLE;
			trial_reg <= 10'h000;
			bit_reg <= 4'h0;
			samp_reg <= 2'h0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					state_reg <= ST_SAMPLE;
					samp_reg <= 2'h0;
				end
				ST_SAMPLE:
				begin
					if (tick)
					begin
						if (samp_reg == 2'(SAMPLE_TICKS - 1))
						begin
							state_reg <= ST_RESOLVE;
							bit_reg <= 4'(RES_W - 1);
							trial_reg <= 10'h200;
						end
						else
							samp_reg <= samp_reg + 2'h1;
					end
				end
				ST_RESOLVE:
				begin
					if (tick)
					begin
						// keep bit when input above trial; msb first
						if (!COMP_ABOVE)
							trial_reg[bit_reg] <= 1'b0;
						if (bit_reg == 4'h0)
							state_reg <= ST_SAMPLE;
						else
						begin
							bit_reg <= bit_reg - 4'h1;
							trial_reg[bit_reg - 4'h1] <= 1'b1;
						end
						samp_reg <= 2'h0;
					end
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// result registers, overwritten every conversion
	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			res_high_reg <= RES_RESET;
			res_low_reg <= RES_RESET;
		end
		else if (finish)
		begin
			res_high_reg <= final_res[RES_W-1:2];
			res_low_reg <= {6'h00, final_res[1:0]};
		end
	end

	// interrupt status, mask and output; set wins over clear
	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_status_reg <= '0;
			irq_mask_reg <= '0;
			irq_reg <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < IRQ_W; i++)
			begin
				if (BUS.wr && hit(BUS.addr, OFF_IRQ_STATUS) && BUS.wdata[i])
					irq_status_reg[i] <= 1'b0;
				if (BUS.wr && hit(BUS.addr, OFF_IRQ_STATUS) && BUS.wdata[i+4])
					irq_mask_reg[i] <= 1'b1;
				else if (BUS.wr && hit(BUS.addr, OFF_IRQ_STATUS) &&
					BUS.wdata[i+6])
					irq_mask_reg[i] <= 1'b0;
			end
			if (finish)
				irq_status_reg[IRQ_DONE] <= 1'b1;
			if (ch_change && state_reg != ST_IDLE)
				irq_status_reg[IRQ_ABORT] <= 1'b1;
			irq_reg <= |(irq_status_reg & irq_mask_reg);
		end
	end

	// read data one cycle after the strobe
	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
			rdata_reg <= 8'h00;
		else if (BUS.rd)
		begin
			case (BUS.addr)
				OFF_CSR: rdata_reg <= csr_reg;
				OFF_RES_HIGH: rdata_reg <= res_high_reg;
				OFF_RES_LOW: rdata_reg <= res_low_reg & LOW_MASK;
				OFF_IRQ_STATUS: rdata_reg <= {2'h0, irq_mask_reg, 2'h0,
					irq_status_reg};
				default: rdata_reg <= 8'h00;
			endcase
		end
		else
			rdata_reg <= 8'h00;
	end

	// analog side outputs from flops
	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
			ANALOG <= '0;
		else
		begin
			ANALOG.channel_select <= csr_reg[CH_W-1:0];
			ANALOG.sample <= (state_reg == ST_SAMPLE);
			ANALOG.trial <= trial_reg;
		end
	end

	assign RDATA = rdata_reg;
	assign IRQ = irq_reg;

	AST_DONE_ON_FINISH: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		finish |=> csr_reg[BIT_DONE])
		else $error("done flag not set after conversion");
	AST_HIGH_READ_CLEARS: assert property (@(posedge CLK_SYS)
		disable iff (!rst_n) high_rd && !finish |=> !csr_reg[BIT_DONE])
		else $error("high read did not clear done");
	AST_OFF_IDLE: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		!conv_on |=> state_reg == ST_IDLE)
		else $error("converter running while off");
	AST_CH_ABORT: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		ch_change |=> state_reg == ST_IDLE && !csr_reg[BIT_DONE])
		else $error("channel change did not restart");
	AST_LOW_ZERO: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		res_low_reg[7:2] == 6'h00)
		else $error("low result upper bits not zero");
	AST_RSVD_ZERO: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		csr_reg[BIT_RSVD] == 1'b0)
		else $error("reserved bit set");
	AST_SLOW_DIV: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		tick && conv_on && !csr_reg[BIT_SPEED] && !csr_wr |=> !tick[*3])
		else $error("slow clock ticks too early");
	AST_RESULT_ON_FINISH: assert property (@(posedge CLK_SYS)
		disable iff (!rst_n)
		finish |=> res_high_reg == $past(final_res[RES_W-1:2]))
		else $error("result not updated");
	AST_START: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		conv_on && state_reg == ST_IDLE && !ch_change |=>
		state_reg == ST_SAMPLE)
		else $error("conversion did not start");
	AST_FINISH_STATE: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		finish |=> state_reg == ST_SAMPLE)
		else $error("no next conversion after finish");

	// reset values
	AST_CSR_RESET: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		$rose(rst_n) |-> csr_reg == CSR_RESET)
		else $error("control register not reset");
	AST_RES_RESET: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		$rose(rst_n) |-> res_high_reg == RES_RESET &&
		res_low_reg == RES_RESET)
		else $error("result registers not reset");

	// register access
	AST_WRITE_CLEARS_DONE: assert property (@(posedge CLK_SYS)
		disable iff (!rst_n) csr_wr && !finish |=> !csr_reg[BIT_DONE])
		else $error("control write did not clear done");
	AST_DONE_ONLY_FINISH: assert property (@(posedge CLK_SYS)
		disable iff (!rst_n) !finish |=> !$rose(csr_reg[BIT_DONE]))
		else $error("done flag set without conversion");
	AST_CSR_WRITE_LANDS: assert property (@(posedge CLK_SYS)
		disable iff (!rst_n) csr_wr |=> (csr_reg & CSR_WRITE_MASK) ==
		$past(BUS.wdata & CSR_WRITE_MASK))
		else $error("control write did not land");
	AST_CSR_HOLDS: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		!csr_wr |=> (csr_reg & CSR_WRITE_MASK) ==
		$past(csr_reg & CSR_WRITE_MASK))
		else $error("control bits changed without write");
	AST_RD_IDLE: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		!$past(BUS.rd) |-> rdata_reg == 8'h00)
		else $error("read data outside read cycle");
	AST_HIGH_READ_DATA: assert property (@(posedge CLK_SYS)
		disable iff (!rst_n) high_rd |=> rdata_reg == $past(res_high_reg))
		else $error("high read data wrong");
	AST_LOW_READ_DATA: assert property (@(posedge CLK_SYS)
		disable iff (!rst_n) BUS.rd && BUS.addr == OFF_RES_LOW |=>
		rdata_reg[7:2] == 6'h00)
		else $error("low read upper bits not zero");

	// results
	AST_RESULT_HOLDS: assert property (@(posedge CLK_SYS)
		disable iff (!rst_n)
		!finish |=> $stable(res_high_reg) && $stable(res_low_reg))
		else $error("result changed without conversion");
	AST_LOW_ON_FINISH: assert property (@(posedge CLK_SYS)
		disable iff (!rst_n)
		finish |=> res_low_reg == {6'h00, $past(final_res[1:0])})
		else $error("low result not updated");

	// converter clock
	AST_DIVIDE_FAST: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		tick && csr_reg[BIT_SPEED] && !csr_wr |=> !tick)
		else $error("fast clock ticks too early");
	AST_DIV_RANGE: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		div_reg <= DIV_SLOW)
		else $error("divider out of range");

	// sequencing
	AST_SAMP_RANGE: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		state_reg == ST_SAMPLE |-> samp_reg < 2'(SAMPLE_TICKS))
		else $error("sample count out of range");
	AST_SAMPLE_TO_RESOLVE: assert property (@(posedge CLK_SYS)
		disable iff (!rst_n) state_reg == ST_SAMPLE && tick && !ch_change &&
		samp_reg == 2'(SAMPLE_TICKS - 1) |=> state_reg == ST_RESOLVE &&
		trial_reg == 10'h200)
		else $error("resolve did not start at msb");
	AST_MSB_FIRST: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		state_reg == ST_RESOLVE && tick && bit_reg != 4'h0 && !ch_change |=>
		bit_reg == $past(bit_reg) - 4'h1)
		else $error("bit order wrong");
	AST_KEEP_BIT: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		state_reg == ST_RESOLVE && tick && COMP_ABOVE && !ch_change |=>
		trial_reg[$past(bit_reg)])
		else $error("bit dropped although input above");
	AST_DROP_BIT: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		state_reg == ST_RESOLVE && tick && !COMP_ABOVE && !ch_change |=>
		!trial_reg[$past(bit_reg)])
		else $error("bit kept although input below");
	AST_HALT_STOPS: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		HALT_MODE |=> state_reg == ST_IDLE)
		else $error("converter running in halt");

	// analog side and interrupt
	AST_CH_OUT: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		ANALOG.channel_select == $past(csr_reg[CH_W-1:0]))
		else $error("channel select not forwarded");
	AST_SAMPLE_OUT: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		ANALOG.sample == $past(state_reg == ST_SAMPLE))
		else $error("sample output wrong");
	AST_NO_SAMPLE_OFF: assert property (@(posedge CLK_SYS)
		disable iff (!rst_n) !conv_on ##1 !conv_on |=> !ANALOG.sample)
		else $error("sampling while off");
	AST_IRQ_LEVEL: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		irq_reg == $past(|(irq_status_reg & irq_mask_reg)))
		else $error("interrupt level wrong");
	AST_ABORT_FLAG: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
		ch_change && state_reg != ST_IDLE |=>
		irq_status_reg[IRQ_ABORT])
		else $error("abort status not set");
endmodule
`default_nettype wire

/* File: dv/sac_analog_model.sv */
// analog mux, sample-and-hold and comparator model
// assumes trial code and select arrive registered from the converter
`default_nettype none
module sac_analog_model
	import sac_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// converter side
	input wire sac_pkg::sac_analog_s analog,
	output logic comp_above
);
	timeunit 1ns;
	timeprecision 1ps;
	int held_x2 = 0;
	// input level in half codes, off scale on both ends
	function automatic int level_x2(input logic [3:0] ch);
		if (ch == 4'h0)
			return -1;
		if (ch == 4'hF)
			return 2050;
		return 2 * (ch * 67 + 9) + 1;
	endfunction
	always @(posedge clk_sys)
		if (analog.sample)
			held_x2 <= level_x2(analog.channel_select);
	assign comp_above = held_x2 > 2 * int'(analog.trial);
endmodule
`default_nettype wire

/* File: dv/sac_adc_control_tb.sv */
// bench for the converter control block: scenarios and verdict
// assumes the analog model on the converter's analog side
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
	$display("Error t=%0t got %h exp %h", $time, g, e); end end
module sac_adc_control_tb;
	import sac_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic halt_mode = 1'b0;
	logic comp_above;
	logic irq;
	logic [7:0] rdata;
	logic [7:0] d;
	sac_bus_s bus = '0;
	sac_analog_s analog;
	int err_total = 0;
	int n_tests = 0;
	int cycles = 0;
	sac_adc_control dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .BUS(bus),
		.RDATA(rdata), .HALT_MODE(halt_mode), .COMP_ABOVE(comp_above),
		.ANALOG(analog), .IRQ(irq));
	sac_analog_model model_u (.clk_sys(clk_sys), .analog(analog),
		.comp_above(comp_above));
	initial
		forever #12.5 clk_sys = ~clk_sys;
	task automatic end_sim();
		$display("tests %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			end_sim();
		end
	end
	function automatic logic [9:0] code(input logic [3:0] ch);
		if (ch == 4'h0)
			return 10'h000;
		if (ch == 4'hF)
			return 10'h3FF;
		return 10'(ch * 67 + 9);
	endfunction
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		bus <= '{1'b1, 1'b0, a, v};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		bus <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1;
		v = rdata;
	endtask
	task automatic wait_done(input int lim);
		d = 8'h00;
		for (int i = 0; i < lim && d[BIT_DONE] !== 1'b1; i++)
			rd(OFF_CSR, d);
	endtask
	task automatic t_reset();
		for (int i = 0; i < 3; i++)
		begin
			rd(2'(i), d);
			`CHK(d, 8'h00)
		end
		$display("reset test done");
	endtask
	task automatic t_rw();
		wr(OFF_CSR, 8'hFF);
		rd(OFF_CSR, d);
		`CHK(d, 8'h6F)
		wr(OFF_CSR, 8'h00);
		rd(OFF_CSR, d);
		`CHK(d, 8'h00)
		$display("csr test done");
	endtask
	task automatic t_conv(input logic [3:0] ch, input logic f);
		logic [7:0] lo;
		logic [9:0] e;
		int n;
		e = code(ch);
		n = 0;
		wr(OFF_CSR, {1'b0, f, 1'b1, 1'b0, ch});
		repeat (2) @(negedge clk_sys);
		while (analog.sample !== 1'b1 && n < 9)
		begin
			@(negedge clk_sys);
			n++;
		end
		n = 0;
		while (analog.sample === 1'b1 && n < 20)
		begin
			@(negedge clk_sys);
			n++;
		end
		`CHK(n, SAMPLE_TICKS * (f ? 2 : 4))
		`CHK(analog.trial, 10'h200)
		wait_done(40);
		`CHK(d[BIT_DONE], 1'b1)
		rd(OFF_RES_LOW, lo);
		rd(OFF_RES_HIGH, d);
		`CHK({d, lo}, {e[9:2], 6'h00, e[1:0]})
		rd(OFF_CSR, d);
		`CHK(d, {1'b0, f, 1'b1, 1'b0, ch})
		wait_done(40);
		rd(OFF_RES_HIGH, d);
		`CHK(d, e[9:2])
		$display("conversion test done");
	endtask
	task automatic t_stop();
		logic [9:0] e;
		e = code(4'h7);
		wr(OFF_CSR, 8'h65);
		repeat (10) @(posedge clk_sys);
		wr(OFF_CSR, 8'h00);
		wait_done(30);
		`CHK(d[BIT_DONE], 1'b0)
		@(posedge clk_sys);
		halt_mode <= 1'b1;
		wr(OFF_CSR, 8'h67);
		wait_done(30);
		`CHK(d[BIT_DONE], 1'b0)
		@(posedge clk_sys);
		halt_mode <= 1'b0;
		wait_done(40);
		`CHK(d[BIT_DONE], 1'b1)
		wr(OFF_CSR, 8'h67);
		rd(OFF_CSR, d);
		`CHK(d, 8'h67)
		rd(OFF_RES_HIGH, d);
		`CHK(d, e[9:2])
		$display("stop test done");
	endtask
	task automatic t_abort();
		logic [9:0] e;
		logic [7:0] w [3] = '{8'h30, 8'hC0, 8'h03};
		logic [8:0] x [3] = '{9'h067, 9'h006, 9'h000};
		e = code(4'h9);
		wr(OFF_CSR, 8'h23);
		repeat (20) @(posedge clk_sys);
		wr(OFF_CSR, 8'h29);
		rd(OFF_CSR, d);
		`CHK(d, 8'h29)
		wait_done(40);
		rd(OFF_RES_HIGH, d);
		`CHK(d, e[9:2])
		wr(OFF_CSR, 8'h00);
		rd(OFF_IRQ_STATUS, d);
		`CHK({d, irq}, 9'h006)
		for (int i = 0; i < 3; i++)
		begin
			wr(OFF_IRQ_STATUS, w[i]);
			rd(OFF_IRQ_STATUS, d);
			`CHK({d, irq}, x[i])
		end
		$display("abort test done");
	endtask
	initial
	begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_reset();
		t_rw();
		t_conv(4'h0, 1'b0);
		t_conv(4'h5, 1'b1);
		t_conv(4'hF, 1'b0);
		t_conv(4'hA, 1'b1);
		t_stop();
		t_abort();
		end_sim();
	end
endmodule
`default_nettype wire
